// ==== verilog/sopm_regs.svh ====
/*
  Constants of the sum-of-products macrocell array: array geometry,
  product-term distribution, register map and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
//==========================================================================
`ifndef SOPM_REGS_SVH
`define SOPM_REGS_SVH

//==========================================================================
// array geometry
`define SOPM_N_IN        14
`define SOPM_N_MC        12
`define SOPM_N_SIG       26
`define SOPM_N_LIT       52
`define SOPM_PT_CNT_LIST 8, 10, 12, 14, 16, 16, 16, 16, 14, 12, 10, 8
`define SOPM_OE_BASE     152
`define SOPM_AR_PT       164
`define SOPM_SP_PT       165
`define SOPM_N_PT        166
`define SOPM_CLK1_BIT    0
`define SOPM_CLK2_BIT    3

//==========================================================================
// register map, byte addresses
`define SOPM_CFG_BASE    12'h0800
`define SOPM_CFG_END     12'h0830
`define SOPM_STAT_FF     12'h0C00
`define SOPM_STAT_PIN    12'h0C04
`define SOPM_STAT_OE     12'h0C08
`define SOPM_STAT_TERM   12'h0C0C

//==========================================================================
// word layout and reset values
`define SOPM_LO_W        32
`define SOPM_HI_W        20
`define SOPM_CFG_W       4
`define SOPM_CFG_RESET   4'hF
`define SOPM_MASK_RESET  52'h0_0000_0000_0000

`endif

// ==== verilog/sopm_pkg.sv ====
/*
  Types of the sum-of-products macrocell array.
  Assumes sopm_regs.svh is on the include path.
*/
`include "sopm_regs.svh"

package sopm_pkg;

  // four configuration bits of one macrocell, polarity in bit 0
  typedef struct packed {
    logic feedback_invert_bit;
    logic clock_select_bit;
    logic path_select_bit;
    logic polarity_select_bit;
  } sopm_cfg_s;

  // one product term's connection mask, bit 2i true, bit 2i+1 inverted
  typedef logic [`SOPM_N_LIT-1:0] sopm_mask_t;

endpackage

// ==== verilog/sopm_array.sv ====
/*
  Sum-of-products macrocell array: programmable AND array, fixed OR array,
  twelve output macrocells, programmed over an Avalon-MM slave.
  Assumes pins and bus are synchronous to ref_clk_in; the bench resolves
  each I/O pin from io_out and io_oe_out and returns its level on io_in.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sopm_regs.svh"

module sopm_array #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              sys_rst_in,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // dedicated inputs, bits 0 and 3 double as clock pins
  input  wire logic [13:0]       ded_in,
  // macrocell i/o pins
  input  wire logic [11:0]       io_in,
  output logic      [11:0]       io_out,
  output logic      [11:0]       io_oe_out
);

  //========================================================================
  // product-term distribution
  localparam int PT_CNT [`SOPM_N_MC] = '{`SOPM_PT_CNT_LIST};

  function automatic int start_of(input int m);
    int s;
    s = 0;
    for (int k = 0; k < m; k++) begin
      s += PT_CNT[k];
    end
    return s;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  //========================================================================
  // storage and state
  sopm_pkg::sopm_mask_t   term_mask [`SOPM_N_PT];
  sopm_pkg::sopm_cfg_s    cfg [`SOPM_N_MC];
  logic [11:0]            ff_q;
  logic [11:0]            ff_eff;
  logic                   clk1_prev;
  logic                   clk2_prev;
  logic                   clk1_rise;
  logic                   clk2_rise;
  logic                   ack;
  logic [31:0]            next_readdata;
  logic [`SOPM_N_SIG-1:0] sig;
  logic [`SOPM_N_LIT-1:0] lit;
  logic [`SOPM_N_PT-1:0]  pt;
  logic [11:0]            sum;
  logic [11:0]            fb;
  logic                   ar_term;
  logic                   sp_term;

  //========================================================================
  // bus decode
  logic [ADDR_W-3:0] word_idx;
  logic [7:0]        t_idx;
  logic              is_term;
  logic              is_cfg;
  logic [3:0]        c_idx;
  logic              wr_go;

  assign word_idx = avs_address_in[ADDR_W-1:2];
  assign t_idx    = word_idx[8:1];
  assign is_term  = (avs_address_in < `SOPM_CFG_BASE) && (t_idx < 8'(`SOPM_N_PT));
  assign is_cfg   = (avs_address_in >= `SOPM_CFG_BASE) && (avs_address_in < `SOPM_CFG_END);
  assign c_idx    = 4'((avs_address_in - `SOPM_CFG_BASE) >> 2);
  assign wr_go    = avs_write_in && ack;

  // one wait state: answer stands in the cycle after the request is seen
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;

  // acknowledge flop
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_in || avs_write_in) && !ack;
    end
  end

  // read data mux
  always_comb begin
    next_readdata = '0;
    if (is_term) begin
      if (!word_idx[0]) begin
        next_readdata = term_mask[t_idx][`SOPM_LO_W-1:0];
      end else begin
        next_readdata = 32'(term_mask[t_idx][`SOPM_N_LIT-1:`SOPM_LO_W]);
      end
    end else if (is_cfg) begin
      next_readdata = 32'(cfg[c_idx]);
    end else begin
      unique case (avs_address_in)
        `SOPM_STAT_FF:   next_readdata = 32'(ff_eff);
        `SOPM_STAT_PIN:  next_readdata = 32'(io_out);
        `SOPM_STAT_OE:   next_readdata = 32'(io_oe_out);
        `SOPM_STAT_TERM: next_readdata = 32'({sp_term, ar_term});
        default:         next_readdata = '0;
      endcase
    end
  end

  // registered read data
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= '0;
    end else if (avs_read_in && !ack) begin
      avs_readdata_out <= next_readdata;
    end
  end

  //========================================================================
  // programming of the and array, erased means nothing connected
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      for (int t = 0; t < `SOPM_N_PT; t++) begin
        term_mask[t] <= `SOPM_MASK_RESET;
      end
    end else if (wr_go && is_term) begin
      if (!word_idx[0]) begin
        term_mask[t_idx][`SOPM_LO_W-1:0] <=
          be_merge(term_mask[t_idx][`SOPM_LO_W-1:0], avs_writedata_in, avs_byteenable_in);
      end else begin
        term_mask[t_idx][`SOPM_N_LIT-1:`SOPM_LO_W] <= `SOPM_HI_W'(
          be_merge(32'(term_mask[t_idx][`SOPM_N_LIT-1:`SOPM_LO_W]),
                   avs_writedata_in, avs_byteenable_in));
      end
    end
  end

  // macrocell configuration, erased bits read 1
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      for (int m = 0; m < `SOPM_N_MC; m++) begin
        cfg[m] <= `SOPM_CFG_RESET;
      end
    end else if (wr_go && is_cfg && avs_byteenable_in[0]) begin
      cfg[c_idx] <= avs_writedata_in[`SOPM_CFG_W-1:0];
    end
  end

  //========================================================================
  // and array
  assign sig = {fb, ded_in};

  // literals in true and inverted form
  generate
    for (genvar i = 0; i < `SOPM_N_SIG; i++) begin : g_lit
      assign lit[2*i]   = sig[i];
      assign lit[2*i+1] = ~sig[i];
    end
  endgenerate

  // each term ands only its connected literals
  generate
    for (genvar t = 0; t < `SOPM_N_PT; t++) begin : g_pt
      assign pt[t] = &(~term_mask[t] | lit);
    end
  endgenerate

  assign ar_term = pt[`SOPM_AR_PT];
  assign sp_term = pt[`SOPM_SP_PT];

  //========================================================================
  // clock pin edges, pins sampled on the system clock
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      clk1_prev <= 1'b0;
      clk2_prev <= 1'b0;
    end else begin
      clk1_prev <= ded_in[`SOPM_CLK1_BIT];
      clk2_prev <= ded_in[`SOPM_CLK2_BIT];
    end
  end

  assign clk1_rise = ded_in[`SOPM_CLK1_BIT] && !clk1_prev;
  assign clk2_rise = ded_in[`SOPM_CLK2_BIT] && !clk2_prev;

  // clear acts on the visible state in the same cycle
  assign ff_eff = ar_term ? '0 : ff_q;

  //========================================================================
  // or array and macrocells
  generate
    for (genvar m = 0; m < `SOPM_N_MC; m++) begin : g_mc
      localparam int START = start_of(m);
      logic tick;
      logic pre_pol;
      logic pin_fb;

      assign sum[m] = |pt[START +: PT_CNT[m]];
      assign tick = cfg[m].clock_select_bit ? clk1_rise : clk2_rise;

      // macrocell flip-flop
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          ff_q[m] <= 1'b0;
        end else if (ar_term) begin
          ff_q[m] <= 1'b0;
        end else if (tick) begin
          ff_q[m] <= sp_term | sum[m];
        end
      end

      // output path and polarity
      assign pre_pol = cfg[m].path_select_bit ? sum[m] : ff_eff[m];
      assign io_out[m] = cfg[m].polarity_select_bit ? pre_pol : ~pre_pol;
      assign io_oe_out[m] = pt[`SOPM_OE_BASE + m];

      // feedback source select
      assign pin_fb = cfg[m].feedback_invert_bit ? cfg[m].path_select_bit
                                                 : ~cfg[m].path_select_bit;
      assign fb[m] = pin_fb ? io_in[m] : ff_eff[m];
    end
  endgenerate

endmodule

`default_nettype wire

// ==== verif/sopm_board.sv ====
/* Board model beside sopm_array: resolves each macrocell pin.
   Assumes the bench gives the board drive used while the array is off. */
`timescale 1ns/10ps
`default_nettype none
module sopm_board (
  // drive from the array and the board
  input  wire logic [11:0] val_in,
  input  wire logic [11:0] oe_in,
  input  wire logic [11:0] drv_in,
  // resolved pin level
  output logic      [11:0] pin_out
);
  //==========
  // array wins where enabled, board elsewhere
  assign pin_out = (val_in & oe_in) | (drv_in & ~oe_in);
endmodule
`default_nettype wire

// ==== verif/sopm_array_checker.sv ====
/* Checker of sopm_array: bus timing and pin relations.
   Assumes binding to sopm_array and a single clock domain. */
`timescale 1ns/10ps
`default_nettype none
`include "sopm_regs.svh"
module sopm_array_checker #(
  parameter int ADDR_W = 12
) (
  // watched ports
  input wire logic              ref_clk_in,
  input wire logic              sys_rst_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [31:0]       avs_readdata_out,
  input wire logic              avs_waitrequest_out,
  input wire logic [13:0]       ded_in,
  input wire logic [11:0]       io_in,
  input wire logic [11:0]       io_out,
  input wire logic [11:0]       io_oe_out
);
  //==========
  // bus phases
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_wait; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  sequence s_done; (avs_read_in || avs_write_in) && !avs_waitrequest_out; endsequence
  AST_WAIT_ONE: assert property (s_wait |=> s_done) else $error("wait not one cycle");
  AST_IDLE: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("wait without request");
  AST_RD_HOLD: assert property (!avs_read_in ##1 !avs_read_in |-> $stable(avs_readdata_out))
    else $error("read data moved");
  AST_UNMAPPED: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in >= 12'h0530 && avs_address_in < `SOPM_CFG_BASE
    |-> avs_readdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  //==========
  // pin relations
  AST_PWR_UP: assert property ($fell(sys_rst_in) |->
    io_out == 12'hFFF && io_oe_out == 12'hFFF) else $error("pins wrong after reset");
  AST_QUIET: assert property ($stable(ded_in) && $stable(io_in) &&
    !$past(avs_write_in && !avs_waitrequest_out) && !($past(ded_in[0]) && !$past(ded_in[0], 2))
    && !($past(ded_in[3]) && !$past(ded_in[3], 2)) |-> $stable(io_out) && $stable(io_oe_out))
    else $error("pins moved without cause");
  AST_STAT_PIN: assert property (s_wait ##0 avs_address_in == `SOPM_STAT_PIN |=>
    avs_readdata_out[11:0] == $past(io_out)) else $error("pin status wrong");
  AST_STAT_OE: assert property (s_wait ##0 avs_address_in == `SOPM_STAT_OE |=>
    avs_readdata_out[11:0] == $past(io_oe_out)) else $error("enable status wrong");
endmodule
bind sopm_array sopm_array_checker #(.ADDR_W(ADDR_W)) sopm_array_checker_i (.ref_clk_in,
  .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
  .avs_waitrequest_out, .ded_in, .io_in, .io_out, .io_oe_out);
`default_nettype wire

// ==== verif/test_sum_of_products_macrocell_array.sv ====
/* Testbench of sopm_array: programs terms and macrocells over the bus.
   Assumes sopm_board resolves the pins and the checker is bound. */
`timescale 1ns/10ps
`default_nettype none
module test_sum_of_products_macrocell_array;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [11:0] adr        = 12'h000;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wd         = 32'h0000_0000;
  logic [3:0]  be         = 4'hF;
  logic [13:0] ded        = 14'h0000;
  logic [11:0] drv        = 12'h000;
  logic [31:0] rdat, q;
  logic        wt;
  logic [11:0] io_o, oe, pin;
  int          fails       = 0;
  int          comparisons = 0;
  // macrocell 0 steps: config, inputs, clock pin to pulse (15 none), pins
  logic [3:0]  cfgs[8] = '{4'hF, 4'hE, 4'h7, 4'h7, 4'h7, 4'h1, 4'h1, 4'h8};
  logic [13:0] deds[8] = '{14'h0020, 14'h0020, 14'h0020, 14'h0020, 14'h0, 14'h0, 14'h0, 14'h0};
  int          pbs[8]  = '{15, 15, 15, 0, 15, 0, 3, 15};
  logic [11:0] exps[8] = '{12'h803, 12'h800, 12'h801, 12'h803, 12'h802, 12'h803, 12'h800, 12'h801};
  //==========
  // clock and design
  always #2 ref_clk_in = ~ref_clk_in;
  sopm_array sopm_array_i (.ref_clk_in, .sys_rst_in, .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .ded_in(ded), .io_in(pin), .io_out(io_o), .io_oe_out(oe));
  sopm_board sopm_board_i (.val_in(io_o), .oe_in(oe), .drv_in(drv), .pin_out(pin));
  //==========
  // tasks
  task automatic err(input string s);
    $display("ERROR %0t %s", $time, s);
    fails++;
  endtask
  task automatic stop_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) err("bus hang");
  endtask
  task automatic set_ded(input logic [13:0] d);
    @(posedge ref_clk_in);
    ded <= d;
  endtask
  task automatic pulse(input int b);
    @(posedge ref_clk_in);
    ded[b] <= 1'b1;
    @(posedge ref_clk_in);
    ded[b] <= 1'b0;
  endtask
  task automatic chk_pin(input logic sel, input logic [11:0] m, input logic [11:0] e);
    @(negedge ref_clk_in);
    comparisons++;
    if (((sel ? oe : io_o) & m) !== e) err("pin mismatch");
  endtask
  task automatic chk_rd(input logic [31:0] e);
    comparisons++;
    if (q !== e) err("read mismatch");
  endtask
  //==========
  // watchdog
  initial begin
    #20000;
    err("timeout");
    stop_test();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    chk_pin(1'b0, 12'hFFF, 12'hFFF);
    chk_pin(1'b1, 12'hFFF, 12'hFFF);
    bus(1'b0, 12'h800, 32'h0); chk_rd(32'h0000_000F);
    bus(1'b0, 12'hC0C, 32'h0); chk_rd(32'h0000_0003);
    bus(1'b0, 12'h400, 32'h0); chk_rd(32'h0000_0000);
    bus(1'b0, 12'h600, 32'h0); chk_rd(32'h0000_0000);
    for (int t = 1; t < 166; t++) begin
      if (t != 17 && t != 151 && (t < 152 || t > 163)) bus(1'b1, 12'(t * 8), 32'h3);
    end
    bus(1'b1, 12'h000, 32'h0000_2400);
    bus(1'b1, 12'h088, 32'h1000_0000);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 12'h800, {28'h000_0000, cfgs[i]});
      set_ded(deds[i]);
      if (pbs[i] < 14) pulse(pbs[i]);
      chk_pin(1'b0, 12'hFFF, exps[i]);
    end
    bus(1'b1, 12'h800, 32'h0);
    bus(1'b1, 12'h4C0, 32'h0000_1000);
    drv <= 12'h001;
    chk_pin(1'b1, 12'hFFF, 12'hFFE);
    chk_pin(1'b0, 12'h002, 12'h002);
    bus(1'b0, 12'hC08, 32'h0); chk_rd(32'h0000_0FFE);
    bus(1'b0, 12'hC04, 32'h0); chk_rd(32'h0000_0803);
    bus(1'b1, 12'h528, 32'h0000_4000);
    bus(1'b1, 12'h520, 32'h0001_0000);
    set_ded(14'h0080);
    pulse(3);
    chk_pin(1'b0, 12'h001, 12'h000);
    set_ded(14'h0100);
    chk_pin(1'b0, 12'h001, 12'h001);
    bus(1'b0, 12'hC00, 32'h0); chk_rd(32'h0000_0000);
    be <= 4'hE;
    bus(1'b1, 12'h808, 32'h0);
    be <= 4'hF;
    bus(1'b0, 12'h808, 32'h0); chk_rd(32'h0000_000F);
    stop_test();
  end
endmodule
`default_nettype wire
